// file: rtl/eeprom_pkg.sv
// constants and state encoding of the two-wire serial memory front end
package eeprom_pkg;

  // ==========================================================================
  // widths and sizes
  localparam int          ADDR_W     = 15;
  localparam int          PAGE_W     = 6;
  localparam int          HI_W       = 7;
  localparam int          ENTRY_W    = ADDR_W + 8;
  localparam logic [6:0]  PAGE_BYTES = 7'h40;
  localparam logic [3:0]  BIT_LAST   = 4'h8;
  localparam logic [3:0]  ACK_SLOT   = 4'h9;
  localparam logic [3:0]  BIT_FIRST  = 4'h0;

  // ==========================================================================
  // synchroniser bit positions
  localparam int SYNC_W   = 6;
  localparam int SI_SCL   = 0;
  localparam int SI_SDA   = 1;
  localparam int SI_WP    = 2;
  localparam int SI_STRAP = 3;

  // ==========================================================================
  // protocol states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_DEVAD = 6'h02,
    ST_ADRHI = 6'h04,
    ST_ADRLO = 6'h08,
    ST_WDATA = 6'h10,
    ST_RDATA = 6'h20
  } proto_state_t;

endpackage

// file: rtl/page_buf.sv
// page buffer: 64 x 8 with one write port and a registered read port
`timescale 1ns/1ps
module page_buf (
  input  wire logic                         mclk,
  input  wire logic                         we,
  input  wire logic [eeprom_pkg::PAGE_W-1:0] waddr,
  input  wire logic [7:0]                   wdata,
  input  wire logic [eeprom_pkg::PAGE_W-1:0] raddr,
  output logic      [7:0]                   rdata
);
  import eeprom_pkg::*;

  logic [7:0] mem [0:(1<<PAGE_W)-1];

  // no reset on purpose: contents are only read after being written
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// file: rtl/eeprom_slave.sv
// two-wire serial memory slave: protocol engine, address counter, page staging
`timescale 1ns/1ps
// Contract
// - operations begin only after a start
// - stop detected anywhere in a transfer
// - stop during read aborts to standby
// - stop during write launches programming
// - sda change with scl high is start/stop
// - byte of eight bits, ninth clock acknowledges
// - busy programming: ignore bus, never acknowledge
// - device address must match code and straps
// - byte write: address, two word bytes, data
// - page write accepts up to 64 bytes
// - program only bytes actually received
// - writes step low six bits, wrap page
// - protect pin high blocks all writes
// - protected write data gets no acknowledge
// - counter keeps last accessed location plus one
// - read sends byte at n, counter n+1
// - read counter steps after eighth bit
// - dummy write loads counter for random read
// - master ack continues, nack plus stop ends
// - read counter wraps past top to zero
// - open strap inputs read as low
// - program only after data and stop after ack
// - start resets protocol state
module eeprom_slave #(
  parameter logic [3:0] DEV_CODE = 4'h5  // arbitrary value
) (
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  input  wire logic                          scl_in,
  input  wire logic                          sda_in,
  output logic                               sda_out,
  output logic                               sda_oe,
  input  wire logic                          wp_in,
  input  wire logic                          strap_addr_bit0,
  input  wire logic                          strap_addr_bit1,
  input  wire logic                          strap_addr_bit2,
  output logic      [eeprom_pkg::ADDR_W-1:0] rd_addr,
  input  wire logic [7:0]                    rd_data,
  output logic                               prog_valid,
  output logic      [eeprom_pkg::ADDR_W-1:0] prog_addr,
  output logic      [7:0]                    prog_data,
  input  wire logic                          prog_ready,
  input  wire logic                          array_busy,
  output logic                               busy
);
  import eeprom_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic [SYNC_W-1:0]  s1;
    logic [SYNC_W-1:0]  s2;
    logic               scl_d;
    logic               sda_d;
    proto_state_t       st;
    logic [3:0]         bitcnt;
    logic [7:0]         sh;
    logic               mack;
    logic               ack_end;
    logic [HI_W-1:0]    hi;
    logic [ADDR_W-1:0]  cnt;
    logic [8:0]         wpage;
    logic [PAGE_W-1:0]  wstart;
    logic [6:0]         nbytes;
    logic               sda_oe;
    logic               sda_out;
    logic               prog;
    logic               pend;
    logic [6:0]         idx;
    logic [ENTRY_W-1:0] e0;
    logic [ENTRY_W-1:0] e1;
    logic               v0;
    logic               v1;
    logic               busy;
    logic [ADDR_W-1:0]  rd_addr;
  } core_t;

  core_t              q;
  core_t              next_q;
  logic               scl;
  logic               sda;
  logic               wp;
  logic [2:0]         straps;
  logic               start_c;
  logic               stop_c;
  logic               rise_c;
  logic               fall_c;
  logic               busy_c;
  logic               match_c;
  logic               pop_c;
  logic               push_c;
  logic               pb_we;
  logic [PAGE_W-1:0]  pb_waddr;
  logic [7:0]         pb_wdata;
  logic [PAGE_W-1:0]  pb_raddr;
  logic [7:0]         pb_rdata;
  logic [ENTRY_W-1:0] entry_c;

  function automatic logic dev_match(input logic [7:0] b, input logic [2:0] s);
    dev_match = (b[7:1] == {DEV_CODE, s});
  endfunction

  // ==========================================================================
  // pin conditioning and bus events
  assign scl     = q.s2[SI_SCL];
  assign sda     = q.s2[SI_SDA];
  assign wp      = q.s2[SI_WP];
  assign straps  = q.s2[SI_STRAP +: 3];
  // sda moving while scl stays high is never data
  assign start_c = scl & q.scl_d & q.sda_d & ~sda;
  assign stop_c  = scl & q.scl_d & ~q.sda_d & sda;
  assign rise_c  = scl & ~q.scl_d;
  assign fall_c  = ~scl & q.scl_d;
  assign busy_c  = q.prog | q.pend | q.v0 | q.v1 | array_busy;
  // open strap pins are pulled low outside, so they simply read zero here
  assign match_c = dev_match(q.sh, straps);
  assign pop_c   = q.v0 & prog_ready;
  assign push_c  = q.pend & ~q.v1;
  assign pb_raddr = PAGE_W'(q.wstart + q.idx[PAGE_W-1:0]);
  assign entry_c = {q.wpage, pb_raddr, pb_rdata};

  page_buf u_page_buf (
    .mclk  (mclk),
    .we    (pb_we),
    .waddr (pb_waddr),
    .wdata (pb_wdata),
    .raddr (pb_raddr),
    .rdata (pb_rdata)
  );

  // ==========================================================================
  // next state
  always_comb begin
    next_q   = q;
    pb_we    = 1'b0;
    pb_waddr = q.cnt[PAGE_W-1:0];
    pb_wdata = q.sh;
    next_q.s1 = {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0, wp_in, sda_in, scl_in};
    next_q.s2 = q.s1;
    next_q.scl_d = scl;
    next_q.sda_d = sda;
    next_q.busy  = busy_c;
    next_q.sda_out = 1'b0;

    if (start_c) begin
      // a start always resynchronises; while busy the bus is ignored
      next_q.st      = busy_c ? ST_IDLE : ST_DEVAD;
      next_q.bitcnt  = BIT_FIRST;
      next_q.sda_oe  = 1'b0;
      next_q.ack_end = 1'b0;
    end else if (stop_c) begin
      // only a stop right after a data ack programs
      if (q.st == ST_WDATA && q.ack_end && q.nbytes != 7'h00 && !wp) begin
        next_q.prog = 1'b1;
        next_q.idx  = 7'h00;
      end
      next_q.st      = ST_IDLE;
      next_q.sda_oe  = 1'b0;
      next_q.ack_end = 1'b0;
    end else if (rise_c && q.st != ST_IDLE) begin
      if (q.bitcnt < BIT_LAST) begin
        next_q.sh      = {q.sh[6:0], (q.st == ST_RDATA) ? 1'b0 : sda};
        next_q.bitcnt  = q.bitcnt + 4'h1;
      end else if (q.bitcnt == ACK_SLOT) begin
        next_q.mack = ~sda;
      end
    end else if (fall_c && q.st != ST_IDLE) begin
      // a stop opens with an scl rise that looks like a data bit, so only a finished bit ends it
      next_q.ack_end = 1'b0;
      if (q.bitcnt == BIT_LAST) begin
        next_q.bitcnt = ACK_SLOT;
        case (q.st)
          ST_DEVAD: begin
            next_q.sda_oe = match_c;
            if (!match_c) begin
              next_q.st = ST_IDLE;
            end
          end
          ST_ADRHI, ST_ADRLO: begin
            next_q.sda_oe = 1'b1;
          end
          ST_WDATA: begin
            if (wp) begin
              next_q.st = ST_IDLE;
            end else begin
              next_q.sda_oe = 1'b1;
              pb_we = 1'b1;
              // only the in-page bits step; extra bytes overwrite
              next_q.cnt[PAGE_W-1:0] = q.cnt[PAGE_W-1:0] + 6'h01;
              next_q.nbytes = (q.nbytes == PAGE_BYTES) ? PAGE_BYTES : q.nbytes + 7'h01;
            end
          end
          ST_RDATA: begin
            next_q.sda_oe = 1'b0;
            next_q.cnt    = q.cnt + 15'h0001;
          end
          default: begin
            next_q.st = ST_IDLE;
          end
        endcase
      end else if (q.bitcnt == ACK_SLOT) begin
        next_q.bitcnt = BIT_FIRST;
        next_q.sda_oe = 1'b0;
        case (q.st)
          ST_DEVAD: begin
            if (q.sh[0]) begin
              next_q.st     = ST_RDATA;
              next_q.sh     = rd_data;
              next_q.sda_oe = ~rd_data[7];
            end else begin
              next_q.st = ST_ADRHI;
            end
          end
          ST_ADRHI: begin
            next_q.hi = q.sh[HI_W-1:0];
            next_q.st = ST_ADRLO;
          end
          ST_ADRLO: begin
            next_q.cnt    = {q.hi, q.sh};
            next_q.wpage  = {q.hi, q.sh[7:6]};
            next_q.wstart = q.sh[PAGE_W-1:0];
            next_q.nbytes = 7'h00;
            next_q.st     = ST_WDATA;
          end
          ST_WDATA: begin
            next_q.ack_end = 1'b1;
          end
          ST_RDATA: begin
            if (q.mack) begin
              next_q.sh     = rd_data;
              next_q.sda_oe = ~rd_data[7];
            end else begin
              next_q.st = ST_IDLE;
            end
          end
          default: begin
            next_q.st = ST_IDLE;
          end
        endcase
      end else if (q.st == ST_RDATA) begin
        next_q.sda_oe = ~q.sh[7];
      end
    end

    // drain staged page bytes toward the array
    if (q.prog && !q.pend) begin
      next_q.pend = 1'b1;
    end
    if (pop_c) begin
      next_q.e0 = q.e1;
      next_q.v0 = q.v1;
      next_q.v1 = 1'b0;
    end
    if (push_c) begin
      next_q.pend = 1'b0;
      next_q.idx  = q.idx + 7'h01;
      if (q.idx + 7'h01 == q.nbytes) begin
        next_q.prog = 1'b0;
      end
      if (!next_q.v0) begin
        next_q.e0 = entry_c;
        next_q.v0 = 1'b1;
      end else begin
        next_q.e1 = entry_c;
        next_q.v1 = 1'b1;
      end
    end
    next_q.rd_addr = next_q.cnt;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q         <= '0;
      q.s1      <= 6'h03;
      q.s2      <= 6'h03;
      q.scl_d   <= 1'b1;
      q.sda_d   <= 1'b1;
      q.st      <= ST_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign sda_out    = q.sda_out;
  assign sda_oe     = q.sda_oe;
  assign rd_addr    = q.rd_addr;
  assign prog_valid = q.v0;
  assign prog_addr  = q.e0[ENTRY_W-1:8];
  assign prog_data  = q.e0[7:0];
  assign busy       = q.busy;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_start_go;
    start_c && !busy_c |=> q.st == ST_DEVAD && q.bitcnt == BIT_FIRST;
  endproperty
  a_start_go: assert property (p_start_go) else $error("start not taken");

  property p_stop_idle;
    stop_c |=> q.st == ST_IDLE && !q.sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not idle");

  property p_busy_ignore;
    start_c && busy_c |=> q.st == ST_IDLE ##1 !q.sda_oe;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("busy answered");

  property p_launch;
    stop_c && q.st == ST_WDATA && q.ack_end && q.nbytes != 7'h00 && !wp
      |=> q.prog ##1 q.pend;
  endproperty
  a_launch: assert property (p_launch) else $error("no programming");

  property p_page_cap;
    q.nbytes <= PAGE_BYTES;
  endproperty
  a_page_cap: assert property (p_page_cap) else $error("page overrun");

  property p_page_hold;
    pb_we |=> q.cnt[ADDR_W-1:PAGE_W] == $past(q.cnt[ADDR_W-1:PAGE_W]);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page bits moved");

  property p_read_step;
    fall_c && q.st == ST_RDATA && q.bitcnt == BIT_LAST
      |=> q.cnt == $past(q.cnt) + 15'h0001 ##1 q.rd_addr == $past(q.cnt, 2) + 15'h0001;
  endproperty
  a_read_step: assert property (p_read_step) else $error("read counter");

  property p_no_match;
    fall_c && q.st == ST_DEVAD && q.bitcnt == BIT_LAST && !match_c
      |=> !q.sda_oe && q.st == ST_IDLE;
  endproperty
  a_no_match: assert property (p_no_match) else $error("foreign address acked");

  property p_wp_nack;
    fall_c && q.st == ST_WDATA && q.bitcnt == BIT_LAST && wp |=> !q.sda_oe [*2];
  endproperty
  a_wp_nack: assert property (p_wp_nack) else $error("protected ack");

  property p_low_only;
    q.sda_out == 1'b0;
  endproperty
  a_low_only: assert property (p_low_only) else $error("sda driven high");

  c_launch: cover property (stop_c && q.st == ST_WDATA && q.ack_end);
  c_seq_read: cover property (fall_c && q.st == ST_RDATA && q.bitcnt == ACK_SLOT && q.mack);
  c_page_full: cover property (q.nbytes == PAGE_BYTES);
  c_stall: cover property (q.v1 && !prog_ready);

endmodule

// file: tb/i2c_master_model.sv
// two-wire bus master model: drives the serial clock and pulls the data line
`timescale 1ns/1ps
module i2c_master_model (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // clock idles high between frames, data released to the pull-up
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // ==========================================================================
  // bit level, 125 ns per bit; data moves only while scl is low
  task automatic bit_out(input logic b);
    sda_pull = ~b;
    #31 scl = 1'b1;
    #62 scl = 1'b0;
    #32;
  endtask

  task automatic bit_in(output logic b);
    sda_pull = 1'b0;
    #31 scl = 1'b1;
    #31 b = sda;
    #31 scl = 1'b0;
    #32;
  endtask

  // ==========================================================================
  // frame level
  task automatic start;
    sda_pull = 1'b0;
    #31 scl = 1'b1;
    #62 sda_pull = 1'b1;
    #62 scl = 1'b0;
    #32;
  endtask

  task automatic stop;
    sda_pull = 1'b1;
    #31 scl = 1'b1;
    #62 sda_pull = 1'b0;
    #125;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = ~a;
  endtask

  // more high acknowledges and asks for the next byte
  task automatic rbyte(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(~more);
  endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the two-wire serial memory slave
`timescale 1ns/1ps
module testbench;
  import eeprom_pkg::*;

  typedef struct packed {logic [7:0] dev; logic ack;} row_t;

  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [7:0] DEV_W = {4'h5, STRAP, 1'b0};

  logic               mclk        = 1'b0;
  logic               sys_rst     = 1'b1;
  logic               wp_in       = 1'b0;
  logic               prog_ready  = 1'b0;
  logic               array_busy  = 1'b0;
  logic               scl, sda_pull, sda, sda_out, sda_oe, prog_valid, busy, ack;
  logic [ADDR_W-1:0]  rd_addr, prog_addr;
  logic [7:0]         rd_data, prog_data, d;
  logic [ENTRY_W-1:0] words[$];
  int                 failures    = 0;
  int                 checks_done = 0;
  row_t               rows[5]     = '{'{8'h5B, 1'b1}, '{8'h3B, 1'b0}, '{8'h59, 1'b0},
                                      '{8'h5F, 1'b0}, '{8'h57, 1'b0}};

  function automatic logic [7:0] exp_rd(input logic [ADDR_W-1:0] a);
    return a[7:0] ^ {1'b0, a[14:8]};
  endfunction

  always #4 mclk = ~mclk;
  // open-drain line with pull-up
  assign sda     = ~sda_pull & (~sda_oe | sda_out);
  assign rd_data = exp_rd(rd_addr);

  always @(posedge mclk) begin
    if (prog_valid & prog_ready) begin
      words.push_back({prog_addr, prog_data});
    end
  end

  i2c_master_model i_mst (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  eeprom_slave #(.DEV_CODE(4'h5)) i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .wp_in(wp_in), .strap_addr_bit0(STRAP[0]),
    .strap_addr_bit1(STRAP[1]), .strap_addr_bit2(STRAP[2]), .rd_addr(rd_addr),
    .rd_data(rd_data), .prog_valid(prog_valid), .prog_addr(prog_addr),
    .prog_data(prog_data), .prog_ready(prog_ready), .array_busy(array_busy), .busy(busy));

  // ==========================================================================
  // helpers
  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // bounded wait for n words taken and the staging drained
  task automatic wait_words(input int n);
    for (int i = 0; i < 300; i++) begin
      if (words.size() >= n && busy === 1'b0) return;
      ticks(1);
    end
    failures++;
    results();
  endtask

  task automatic word_addr(input logic [7:0] hi, input logic [7:0] lo);
    i_mst.start();
    i_mst.wbyte(DEV_W, ack);
    i_mst.wbyte(hi, ack);
    i_mst.wbyte(lo, ack);
  endtask

  initial begin
    #500000;
    failures++;
    results();
  end

  // ==========================================================================
  // main sequence
  initial begin
    ticks(20);
    chk("rst_oe", sda_oe, 0);
    chk("rst_valid", prog_valid, 0);
    chk("rst_addr", rd_addr, 0);
    sys_rst = 1'b0;
    ticks(3);
    foreach (rows[i]) begin
      i_mst.start();
      i_mst.wbyte(rows[i].dev, ack);
      chk("addr_ack", ack, rows[i].ack);
      if (rows[i].ack) begin
        i_mst.rbyte(1'b0, d);
        chk("cur_read", d, exp_rd(15'h0000));
      end
      i_mst.stop();
    end
    chk("counter", rd_addr, 15'h0001);
    // page write across the low-six wrap with the array stalled
    word_addr(8'hC1, 8'h3E);
    for (int i = 0; i < 4; i++) begin
      i_mst.wbyte(8'h30 + 8'(i), ack);
      chk("wr_ack", ack, 1);
    end
    i_mst.stop();
    ticks(20);
    chk("busy_stall", busy, 1);
    chk("stall_cnt", words.size(), 0);
    prog_ready = 1'b1;
    wait_words(4);
    for (int i = 0; i < 4; i++) begin
      chk("prog_word", words[i], {7'h41, 2'h0, 6'(6'h3E + i), 8'h30 + 8'(i)});
    end
    ticks(1);
    prog_ready = 1'b0;
    array_busy = 1'b1;
    i_mst.start();
    i_mst.wbyte(DEV_W | 8'h01, ack);
    chk("poll_busy", ack, 0);
    i_mst.stop();
    ticks(1);
    array_busy = 1'b0;
    wait_words(4);
    i_mst.start();
    i_mst.wbyte(DEV_W | 8'h01, ack);
    chk("poll_done", ack, 1);
    i_mst.rbyte(1'b0, d);
    chk("after_wr", d, exp_rd(15'h4102));
    i_mst.stop();
    // random read over the top of the array
    word_addr(8'h7F, 8'hFF);
    i_mst.start();
    i_mst.wbyte(DEV_W | 8'h01, ack);
    i_mst.rbyte(1'b1, d);
    chk("rand_rd", d, exp_rd(15'h7FFF));
    i_mst.rbyte(1'b0, d);
    chk("wrap_rd", d, exp_rd(15'h0000));
    i_mst.stop();
    chk("rd_count", rd_addr, 15'h0001);
    chk("dummy_wr", words.size(), 4);
    // dummy write closed by a stop: counter loads, nothing programs
    word_addr(8'h00, 8'h20);
    i_mst.stop();
    ticks(20);
    chk("dummy_cnt", rd_addr, 15'h0020);
    chk("dummy_busy", busy, 0);
    chk("dummy_words", words.size(), 4);
    // protected write is refused
    ticks(1);
    wp_in = 1'b1;
    word_addr(8'h00, 8'h10);
    i_mst.wbyte(8'hAA, ack);
    chk("wp_ack", ack, 0);
    i_mst.stop();
    ticks(20);
    chk("wp_busy", busy, 0);
    chk("wp_words", words.size(), 4);
    chk("idle_oe", sda_oe, 0);
    chk("sda_out", sda_out, 0);
    wp_in = 1'b0;
    results();
  end
endmodule
